// file: core/blie_exec.sv
// Notes on behaviour
// - register execute-indirect: pc low 8 bits become literal plus register.
// - execute-indirect does not increment pc nor touch the overflow flag.
// - after the target instruction, flow resumes sequentially unless it branched.
// - i/o execute-indirect: pc low 5 bits become literal plus rotated masked data.
// - i/o sources keep length bits from lsb, higher bits forced zero.
// - register branch-if-nonzero: non-zero loads pc low 8 bits, else increment.
// - i/o branch-if-nonzero tests rotated masked data; loads low 5 pc bits.
// - source codes 07, 17 and 20-37 octal are not register form.
// - register immediate forms take an 8-bit literal 000-377 octal.
// - i/o immediate forms take a 5-bit literal 00-37 octal.
// - register literal transmit writes the 8-bit literal to the named register.
// - i/o literal transmit shifts literal, merges length bits into bus data.
// - i/o transmit length above five bits drives the extra bits as zero.
// - absolute jump loads the 13-bit address field into pc.
// - right-bank select is always the complement of left-bank select.
// - i/o operand is bus data right-rotated by source code, then masked.
// - any right-rotation completes within one instruction cycle.
module blie_exec
	import blie_pkg::*;
#(
	parameter int AW = 13
) (
	input  wire logic          core_clk_in,
	input  wire logic          rstn_in,
	input  wire logic [15:0]   instr_in,
	input  wire logic [7:0]    io_bus_data_in,
	input  wire logic          overflow_flag_in,
	output logic      [AW-1:0] pc_out,
	output logic               phase_out,
	output logic               select_command_strobe_out,
	output logic               write_command_strobe_out,
	output logic               left_bank_select_out,
	output logic               right_bank_select_out,
	output logic      [7:0]    io_bus_data_out,
	output logic               io_bus_oe_out,
	output logic               reg_wr_out,
	output logic      [4:0]    reg_wr_addr_out,
	output logic      [7:0]    reg_wr_data_out
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	blie_phase_e     phase;
	logic [AW-1:0]   pc;
	logic [AW-1:0]   ret_pc;
	logic            xec_active;
	logic [15:0]     ir;
	logic [7:0]      regs [0:15];

	// ----------------------------------------------------------------
	// field decode of the instruction in the input phase
	// ----------------------------------------------------------------
	wire [2:0]  op      = instr_in[BLIE_OP_MSB:BLIE_OP_LSB];
	wire [4:0]  sd      = instr_in[BLIE_SD_MSB:BLIE_SD_LSB];
	wire [7:0]  j8      = instr_in[7:0];
	wire [4:0]  j5      = instr_in[BLIE_J5_MSB:0];
	wire [2:0]  len     = instr_in[BLIE_LEN_MSB:BLIE_LEN_LSB];
	wire        is_io   = sd[BLIE_SD_IO_BIT];
	wire        in_ph   = (phase == BLIE_PH_INPUT);
	wire        is_xec  = in_ph && (op == BLIE_OP_XEC);
	wire        is_nzt  = in_ph && (op == BLIE_OP_NZT);
	wire        is_literal_transmit = in_ph && (op == BLIE_OP_LITERAL_TRANSMIT);
	wire        is_jmp  = in_ph && (op == BLIE_OP_JMP);
	wire        addr_sd = (sd == BLIE_SD_IOL) || (sd == BLIE_SD_IOR);

	// register source: address registers read zero, code 10 is the flag
	wire [7:0]  src_reg = addr_sd ? BLIE_BYTE_RESET :
		(sd == BLIE_SD_OVF) ? {7'h00, overflow_flag_in} : regs[sd[3:0]];

	// i/o source operand and the length mask, one combinational pass
	logic [7:0] io_src;
	logic [7:0] len_mask;
	blie_rot_mask #(.W(8), .SW(3)) u_src (
		.data_in  (io_bus_data_in),
		.rot_in   (sd[2:0]),
		.len_in   (len),
		.data_out (io_src),
		.mask_out (len_mask)
	);

	// ----------------------------------------------------------------
	// next program address
	// ----------------------------------------------------------------
	wire [7:0]    xec_low8  = j8 + src_reg;
	wire [4:0]    xec_low5  = j5 + io_src[4:0];
	wire [AW-1:0] xec_tgt   = is_io ? {pc[AW-1:5], xec_low5} : {pc[AW-1:8], xec_low8};
	wire [AW-1:0] nzt_tgt   = is_io ? {pc[AW-1:5], j5} : {pc[AW-1:8], j8};
	wire          nonzero   = is_io ? (io_src != 8'h00) : (src_reg != 8'h00);
	wire [AW-1:0] pc_inc    = pc + {{(AW-1){1'b0}}, 1'b1};
	wire [AW-1:0] seq_pc    = xec_active ? ret_pc : pc_inc;
	wire [AW-1:0] next_pc   = is_xec ? xec_tgt :
		is_nzt ? (nonzero ? nzt_tgt : seq_pc) :
		is_jmp ? instr_in[BLIE_ADDR_MSB:0] : seq_pc;

	// ----------------------------------------------------------------
	// literal transmit data path
	// ----------------------------------------------------------------
	wire [7:0]  lit_m    = {3'h0, j5} & len_mask;
	wire [15:0] lit_dbl  = {lit_m, lit_m} << sd[2:0];
	wire [15:0] msk_dbl  = {len_mask, len_mask} << sd[2:0];
	wire [7:0]  ins_mask = msk_dbl[15:8];
	wire [7:0]  merged   = (io_bus_data_in & ~ins_mask) | (lit_dbl[15:8] & ins_mask);
	wire        reg_dest = !is_io && !addr_sd && (sd != BLIE_SD_OVF);
	wire        literal_transmit_reg = is_literal_transmit && reg_dest;

	// ----------------------------------------------------------------
	// bus strobes: input phase from instr_in, output phase from ir
	// ----------------------------------------------------------------
	wire [2:0]  ir_op    = ir[BLIE_OP_MSB:BLIE_OP_LSB];
	wire [4:0]  ir_sd    = ir[BLIE_SD_MSB:BLIE_SD_LSB];
	wire        ir_literal_transmit  = (ir_op == BLIE_OP_LITERAL_TRANSMIT);
	wire        ir_io    = ir_sd[BLIE_SD_IO_BIT];
	wire        ir_addr  = ir_literal_transmit && ((ir_sd == BLIE_SD_IOL) || (ir_sd == BLIE_SD_IOR));
	wire        bank_in  = is_io && (is_xec || is_nzt || is_literal_transmit) && sd[BLIE_SD_BANK_BIT];
	wire        bank_out = ir_literal_transmit && (ir_io ? ir_sd[BLIE_SD_BANK_BIT] : (ir_sd == BLIE_SD_IOR));
	wire        out_ph   = (phase == BLIE_PH_OUTPUT);

	assign select_command_strobe_out = out_ph && ir_addr;
	assign write_command_strobe_out  = out_ph && ir_literal_transmit && ir_io;
	assign left_bank_select_out      = out_ph ? bank_out : bank_in;
	assign right_bank_select_out     = !left_bank_select_out;
	assign pc_out    = pc;
	assign phase_out = phase;

	// ----------------------------------------------------------------
	// phase, program counter, return address
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			phase      <= BLIE_PH_INPUT;
			pc         <= BLIE_PC_RESET;
			ret_pc     <= BLIE_PC_RESET;
			xec_active <= 1'b0;
			ir         <= 16'h0000;
		end else if (in_ph) begin
			phase      <= BLIE_PH_OUTPUT;
			pc         <= next_pc;
			ret_pc     <= (is_xec && !xec_active) ? pc_inc : ret_pc;
			xec_active <= is_xec || (xec_active && is_xec);
			ir         <= instr_in;
		end else begin
			phase      <= BLIE_PH_INPUT;
		end
	end

	// ----------------------------------------------------------------
	// i/o bus output latch
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			io_bus_data_out <= BLIE_BYTE_RESET;
			io_bus_oe_out   <= 1'b0;
		end else if (in_ph) begin
			io_bus_data_out <= (is_literal_transmit && is_io) ? merged : j8;
			io_bus_oe_out   <= is_literal_transmit && (is_io || addr_sd);
		end else begin
			io_bus_oe_out   <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// internal register write by literal transmit
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			reg_wr_out      <= 1'b0;
			reg_wr_addr_out <= 5'h00;
			reg_wr_data_out <= BLIE_BYTE_RESET;
		end else begin
			reg_wr_out      <= literal_transmit_reg;
			reg_wr_addr_out <= sd;
			reg_wr_data_out <= j8;
		end
	end

	// register array has no reset; software loads it before use
	always_ff @(posedge core_clk_in) begin
		if (literal_transmit_reg) begin
			regs[sd[3:0]] <= j8;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rstn_in);

	property p_xec_reg;
		is_xec && !is_io |=> pc[7:0] == $past(xec_low8) && pc[AW-1:8] == $past(pc[AW-1:8]);
	endproperty
	a_xec_reg: assert property (p_xec_reg) else $error("register xec target wrong");

	property p_xec_no_inc;
		is_xec && (xec_low8 != pc_inc[7:0]) && !is_io |=> pc != $past(pc_inc);
	endproperty
	a_xec_no_inc: assert property (p_xec_no_inc) else $error("xec incremented pc");

	property p_xec_return;
		is_xec && !xec_active ##2 (in_ph && op != BLIE_OP_XEC && op != BLIE_OP_NZT
			&& op != BLIE_OP_JMP) |=> pc == $past(pc, 3) + 13'h0001;
	endproperty
	a_xec_return: assert property (p_xec_return) else $error("no return after xec");

	property p_xec_io;
		is_xec && is_io |=> pc[4:0] == $past(xec_low5) && pc[AW-1:5] == $past(pc[AW-1:5]);
	endproperty
	a_xec_io: assert property (p_xec_io) else $error("i/o xec target wrong");

	property p_len_mask;
		in_ph && is_io |-> (io_src & ~len_mask) == 8'h00;
	endproperty
	a_len_mask: assert property (p_len_mask) else $error("masked bits not zero");

	property p_nzt_reg;
		is_nzt && !is_io && !xec_active |=> pc == ($past(nonzero) ?
			{$past(pc[AW-1:8]), $past(j8)} : $past(pc) + 13'h0001);
	endproperty
	a_nzt_reg: assert property (p_nzt_reg) else $error("register nzt wrong");

	property p_nzt_io;
		is_nzt && is_io && (io_src != 8'h00) |=> pc[4:0] == $past(j5);
	endproperty
	a_nzt_io: assert property (p_nzt_io) else $error("i/o nzt wrong");

	property p_literal_transmit_reg;
		literal_transmit_reg |=> reg_wr_out && reg_wr_data_out == $past(j8) && regs[$past(sd[3:0])] == $past(j8);
	endproperty
	a_literal_transmit_reg: assert property (p_literal_transmit_reg) else $error("register transmit wrong");

	property p_literal_transmit_io;
		is_literal_transmit && is_io && len == 3'h0 && sd[2:0] == 3'h0 |=> io_bus_data_out[7:5] == 3'h0;
	endproperty
	a_literal_transmit_io: assert property (p_literal_transmit_io) else $error("extra literal bits not zero");

	property p_jmp;
		is_jmp |=> pc == $past(instr_in[BLIE_ADDR_MSB:0]);
	endproperty
	a_jmp: assert property (p_jmp) else $error("jump address wrong");

	property p_bank_comp;
		right_bank_select_out != left_bank_select_out;
	endproperty
	a_bank_comp: assert property (p_bank_comp) else $error("bank selects not complementary");

	property p_bank_in;
		(is_xec || is_nzt) && is_io |-> left_bank_select_out == sd[BLIE_SD_BANK_BIT] &&
			!select_command_strobe_out && !write_command_strobe_out;
	endproperty
	a_bank_in: assert property (p_bank_in) else $error("input phase bank select wrong");

	property p_literal_transmit_out;
		is_literal_transmit && is_io |=> write_command_strobe_out && io_bus_oe_out &&
			left_bank_select_out == $past(sd[BLIE_SD_BANK_BIT]);
	endproperty
	a_literal_transmit_out: assert property (p_literal_transmit_out) else $error("transmit output phase wrong");

	c_xec_io: cover property (is_xec && is_io ##2 in_ph);
	c_nzt_taken: cover property (is_nzt && nonzero);
	c_literal_transmit_io: cover property (is_literal_transmit && is_io ##1 write_command_strobe_out);
	c_jmp: cover property (is_jmp);

endmodule : blie_exec

// file: core/blie_pkg.sv
package blie_pkg;

	// ----------------------------------------------------------------
	// instruction word layout (bit 15 is the first opcode bit)
	// ----------------------------------------------------------------
	localparam int             BLIE_OP_MSB     = 15;
	localparam int             BLIE_OP_LSB     = 13;
	localparam int             BLIE_SD_MSB     = 12;
	localparam int             BLIE_SD_LSB     = 8;
	localparam int             BLIE_LEN_MSB    = 7;
	localparam int             BLIE_LEN_LSB    = 5;
	localparam int             BLIE_J5_MSB     = 4;
	localparam int             BLIE_ADDR_MSB   = 12;

	// ----------------------------------------------------------------
	// opcode classes handled here
	// ----------------------------------------------------------------
	localparam logic [2:0]     BLIE_OP_XEC     = 3'h4;
	localparam logic [2:0]     BLIE_OP_NZT     = 3'h5;
	localparam logic [2:0]     BLIE_OP_LITERAL_TRANSMIT    = 3'h6;
	localparam logic [2:0]     BLIE_OP_JMP     = 3'h7;

	// ----------------------------------------------------------------
	// source / destination codes
	// ----------------------------------------------------------------
	localparam logic [4:0]     BLIE_SD_IOL     = 5'h07;
	localparam logic [4:0]     BLIE_SD_OVF     = 5'h08;
	localparam logic [4:0]     BLIE_SD_IOR     = 5'h0F;
	localparam int             BLIE_SD_IO_BIT  = 4;
	localparam int             BLIE_SD_BANK_BIT = 3;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [12:0]    BLIE_PC_RESET   = 13'h0000;
	localparam logic [7:0]     BLIE_BYTE_RESET = 8'h00;

	typedef enum logic [0:0] {
		BLIE_PH_INPUT  = 1'b0,
		BLIE_PH_OUTPUT = 1'b1
	} blie_phase_e;

endpackage : blie_pkg

// file: core/blie_rot_mask.sv
// right-rotates a byte and keeps the low len bits (len 0 keeps all eight)
module blie_rot_mask
	import blie_pkg::*;
#(
	parameter int W  = 8,
	parameter int SW = 3
) (
	input  wire logic [W-1:0]  data_in,
	input  wire logic [SW-1:0] rot_in,
	input  wire logic [SW-1:0] len_in,
	output logic      [W-1:0]  data_out,
	output logic      [W-1:0]  mask_out
);

	// ----------------------------------------------------------------
	// rotate and mask
	// ----------------------------------------------------------------
	logic [2*W-1:0] dbl;
	logic [W-1:0]   rotated;
	logic [W:0]     ones;

	// doubling the word turns the rotate into a plain shift
	assign dbl      = {data_in, data_in} >> rot_in;
	assign rotated  = dbl[W-1:0];
	assign ones     = ({{W{1'b0}}, 1'b1} << len_in) - {{W{1'b0}}, 1'b1};
	assign mask_out = (len_in == '0) ? {W{1'b1}} : ones[W-1:0];
	assign data_out = rotated & mask_out;

endmodule : blie_rot_mask

// file: testbench/blie_io_port.sv
// two-bank i/o port model standing on the far side of the i/o bus
module blie_io_port
	import blie_pkg::*;
(
	input  wire logic       core_clk_in,
	input  wire logic       rstn_in,
	input  wire logic       left_bank_select_in,
	input  wire logic       write_command_strobe_in,
	input  wire logic       io_bus_oe_in,
	input  wire logic [7:0] io_bus_data_in,
	output logic      [7:0] io_bus_data_out
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] port_q [2];

	// ----------------------------------------------------------------
	// bus level
	// ----------------------------------------------------------------
	// design data while it drives, else the latch of the selected bank
	assign io_bus_data_out = io_bus_oe_in ? io_bus_data_in : port_q[left_bank_select_in];

	// latches take the bus on the write strobe, bank chosen by select
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			port_q[0] <= 8'hFF;
			port_q[1] <= 8'hFF;
		end else if (write_command_strobe_in) begin
			port_q[left_bank_select_in] <= io_bus_data_out;
		end
	end
endmodule : blie_io_port

// file: testbench/branch_literal_instr_exec_tb_top.sv
// self-checking bench for the branch, literal and jump execution block
module branch_literal_instr_exec_tb_top
	import blie_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        core_clk_in;
	logic        rstn_in;
	logic [15:0] instr_in;
	logic        overflow_flag_in;
	wire  [7:0]  io_bus_data_in;
	wire  [12:0] pc_out;
	wire         phase_out, sc, wc, lb, rb, oe, rw;
	wire  [7:0]  dout, rw_data;
	wire  [4:0]  rw_addr;
	int          errors;
	int          n_compared;
	int          cycles;

	blie_exec u_blie_exec (
		.core_clk_in(core_clk_in), .rstn_in(rstn_in), .instr_in(instr_in),
		.io_bus_data_in(io_bus_data_in), .overflow_flag_in(overflow_flag_in),
		.pc_out(pc_out), .phase_out(phase_out), .select_command_strobe_out(sc),
		.write_command_strobe_out(wc), .left_bank_select_out(lb),
		.right_bank_select_out(rb), .io_bus_data_out(dout), .io_bus_oe_out(oe),
		.reg_wr_out(rw), .reg_wr_addr_out(rw_addr), .reg_wr_data_out(rw_data)
	);

	blie_io_port u_blie_io_port (
		.core_clk_in(core_clk_in), .rstn_in(rstn_in), .left_bank_select_in(lb),
		.write_command_strobe_in(wc), .io_bus_oe_in(oe), .io_bus_data_in(dout),
		.io_bus_data_out(io_bus_data_in)
	);

	// ----------------------------------------------------------------
	// clock, hang limit and result reporting
	// ----------------------------------------------------------------
	initial begin
		core_clk_in = 1'b0;
		forever #2 core_clk_in = ~core_clk_in;
	end

	// about fifty cycles are needed; cut off far beyond that
	always @(posedge core_clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			errors++;
			close_out();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic close_out();
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : close_out

	// one instruction: lb = {input phase, output phase}, fl = {wc, sc, oe, rw}
	task automatic step(input logic [15:0] ins, input logic [12:0] pc, input logic [1:0] l,
			input logic [3:0] fl, input logic [7:0] d);
		instr_in <= ins;
		#1;
		check(lb, l[1]);
		check(rb, !lb);
		@(posedge core_clk_in);
		#1;
		check(pc_out, pc);
		check({wc, sc, oe, rw}, fl);
		check(rb, !lb);
		if (fl[1]) check(dout, d);
		if (fl[1]) check(lb, l[0]);
		if (fl[0]) check({rw_addr, rw_data}, {ins[12:8], d});
		@(posedge core_clk_in);
	endtask : step

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		#1;
		check({pc_out, phase_out, rb, wc, oe}, {13'h0000, 4'h4});
		$display("test reset done");
	endtask : t_reset

	// register forms: transmit, execute-indirect and return, branches, jump
	task automatic t_reg_forms();
		step(16'hC135, 13'h0001, 2'h0, 4'h1, 8'h35);
		step(16'hC200, 13'h0002, 2'h0, 4'h1, 8'h00);
		step(16'h8110, 13'h0045, 2'h0, 4'h0, 8'h00);
		step(16'h0000, 13'h0003, 2'h0, 4'h0, 8'h00);
		step(16'hA180, 13'h0080, 2'h0, 4'h0, 8'h00);
		step(16'hA280, 13'h0081, 2'h0, 4'h0, 8'h00);
		step(16'hA855, 13'h0055, 2'h0, 4'h0, 8'h00);
		overflow_flag_in <= 1'b0;
		step(16'hA855, 13'h0056, 2'h0, 4'h0, 8'h00);
		step(16'hC7A5, 13'h0057, 2'h0, 4'h6, 8'hA5);
		step(16'hCFA5, 13'h0058, 2'h1, 4'h6, 8'hA5);
		step(16'hC842, 13'h0059, 2'h0, 4'h0, 8'h00);
		step(16'hF234, 13'h1234, 2'h0, 4'h0, 8'h00);
		$display("test register forms done");
	endtask : t_reg_forms

	// i/o transmit merges into latch data, extra length bits cleared
	task automatic t_io_literal_transmit();
		step(16'hD01F, 13'h1235, 2'h0, 4'hA, 8'h1F);
		step(16'hD065, 13'h1236, 2'h0, 4'hA, 8'h1D);
		step(16'hD8FF, 13'h1237, 2'h3, 4'hA, 8'h9F);
		$display("test io transmit done");
	endtask : t_io_literal_transmit

	// i/o execute-indirect and branches on rotated, masked port data
	task automatic t_io_branch();
		step(16'h9183, 13'h1231, 2'h0, 4'h0, 8'h00);
		step(16'h0000, 13'h1238, 2'h0, 4'h0, 8'h00);
		step(16'hB92A, 13'h122A, 2'h2, 4'h0, 8'h00);
		step(16'hBE2A, 13'h122B, 2'h2, 4'h0, 8'h00);
		$display("test io branch done");
	endtask : t_io_branch

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		errors = 0;
		n_compared = 0;
		cycles = 0;
		rstn_in = 1'b0;
		instr_in = 16'h0000;
		overflow_flag_in = 1'b1;
		repeat (9) @(posedge core_clk_in);
		t_reset();
		@(posedge core_clk_in);
		rstn_in <= 1'b1;
		t_reg_forms();
		t_io_literal_transmit();
		t_io_branch();
		close_out();
	end
endmodule : branch_literal_instr_exec_tb_top
